/* File: bench/phrc_src.sv */
// Purpose: path byte source and fifo reader model
// Assumes: shares mclk with the controller
// Notes:   idle data shows the inverted last byte
`timescale 1ns/1ps
module phrc_src import phrc_pkg::*; (
  // clock
  input  wire logic       mclk,
  // fifo write side, path bytes out and fifo_full
  input  wire logic       fifo_wr,
  input  wire phrc_fifo_t fifo_word,
  output phrc_rx_t        rx,
  output logic            fifo_full
);
  int drop_cnt;
  initial begin
    rx = '0;
    fifo_full = 1'b0;
    drop_cnt = 0;
  end
  // ------------------------------------------------------------
  // byte source, random stalls so slow paths get exercised
  // ------------------------------------------------------------
  task automatic send(logic [7:0] q[$], logic bad);
    foreach (q[i]) begin
      @(posedge mclk);
      rx <= '{1'b1, bad && i == q.size() - 1, q[i]};
      if ($urandom_range(0, 3) == 0) begin
        @(posedge mclk);
        rx <= '{1'b0, 1'b0, ~q[i]};
      end
    end
    @(posedge mclk);
    rx <= '{1'b0, 1'b0, ~q[q.size() - 1]};
  endtask
  // reader throws away packets closed with an error
  always @(posedge mclk)
    if (fifo_wr === 1'b1 && fifo_word.end_mark && fifo_word.err)
      drop_cnt <= drop_cnt + 1;
endmodule

/* File: bench/phrc_top_tb.sv */
// Purpose: self-checking bench of the receive hdlc block
// Assumes: phrc_src drives path bytes and fifo_full
// Notes:   queue model checked at every fifo write, except data writes while skip_data is set
`timescale 1ns/1ps
module phrc_top_tb import phrc_pkg::*; ;
  logic        mclk, rstn, hsel, hwrite, hreadyout, hresp;
  logic        fifo_wr, fifo_full, skip_data;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [15:0] cfg;
  logic [7:0]  pay[$];
  logic [47:0] hist;
  phrc_fifo_t  fifo_word, eq[$];
  phrc_rx_t    rx;
  int          error_cnt, total_checks, nbytes, nframes, drops;
  phrc_top uut (.mclk(mclk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .rx(rx), .fifo_full(fifo_full), .fifo_wr(fifo_wr),
    .fifo_word(fifo_word));
  phrc_src src (.mclk(mclk), .fifo_wr(fifo_wr), .fifo_word(fifo_word),
    .rx(rx), .fifo_full(fifo_full));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // ------------------------------------------------------------
  // checks and bus cycles
  // ------------------------------------------------------------
  task automatic chk_reg(string n, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_ent(phrc_fifo_t e, phrc_fifo_t g);
    chk_reg("fifo entry", 32'(e), 32'(g));
  endtask
  task automatic ahb(logic w, logic [7:0] a, logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    ahb(1'b1, a, d);
    if (a == 8'h60) cfg = d[15:0] & 16'h1FFF;
  endtask
  // idle cycle first: no read right behind a write
  task automatic rchk(string n, logic [7:0] a, logic [31:0] e);
    @(posedge mclk);
    ahb(1'b0, a, 32'h0);
    chk_reg(n, e, rd);
    chk_reg("response", 32'h0, {31'h0, hresp});
  endtask
  task automatic mk(int n);
    pay = {};
    repeat (n) pay.push_back(8'($urandom_range(0, 124)));
  endtask
  // reference model of one frame, then send it
  task automatic frame(logic [7:0] c[$], logic bad, logic full);
    logic [7:0] d[$];
    logic [7:0] o;
    int s;
    int e;
    for (int i = 0; i < c.size(); i++)
      if (c[i] == 8'h7D && i + 1 < c.size() && c[i + 1] == 8'h7D) begin
        if (!cfg[7]) d.push_back(8'h5D);
        i++;
      end else d.push_back(c[i]);
    // x48 + x28 + x27 + 1, lsb first; history runs even when off
    foreach (d[j]) begin
      o = d[j];
      for (int b = 0; b < 8; b++) begin
        o[b] = d[j][b] ^ (cfg[8] & (hist[26] ^ hist[27] ^ hist[47]));
        hist = {hist[46:0], d[j][b]};
      end
      d[j] = o;
    end
    s = cfg[1] ? 0 : 2;
    e = (cfg[9] && !cfg[1]) ? d.size() : d.size() - 4;
    nframes += !(full && cfg[12]);
    if (!full) begin
      if (!skip_data) for (int i = s; i < e; i++) begin
        eq.push_back('{i == s, 1'b0, 1'b0, d[i]});
        nbytes += !(cfg[11] && bad);
      end
      eq.push_back('{1'b0, 1'b1, skip_data | (bad & cfg[10]), 8'h00});
      drops += skip_data | (bad & cfg[10]);
    end
    src.send({8'h7E, c, 8'h7E}, bad);
    repeat (6) @(posedge mclk);
  endtask
  always @(posedge mclk)
    if (fifo_wr === 1'b1 && !(skip_data && fifo_word.end_mark !== 1'b1))
      if (eq.size() == 0) chk_ent('1, fifo_word);
      else chk_ent(eq.pop_front(), fifo_word);
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #2000000;
    error_cnt++;
    finish_test();
  end
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    skip_data = 1'b0;
    error_cnt = 0;
    total_checks = 0;
    nbytes = 0;
    nframes = 0;
    drops = 0;
    hist = '0;
    void'($urandom(96360));
    repeat (16) @(posedge mclk);
    rstn <= 1'b1;
    repeat (3) @(posedge mclk);
    rchk("config", 8'h60, 32'h6F);
    rchk("max length", 8'h64, 32'h5DC);
    rchk("unmapped", 8'h7C, 32'h0);
    wr(8'h60, 32'hFFFF_FFFF);
    rchk("config", 8'h60, 32'h1FFF);
    $display("register test done");
    for (int k = 0; k < 16; k++) begin
      wr(8'h60, {k[3], k[2], k[1], k[2], 6'h0, k[0], 1'b0});
      mk($urandom_range(7, 14));
      frame(pay, 1'($urandom_range(0, 1)), 1'b0);
    end
    rchk("byte count", 8'h6C, nbytes);
    $display("field test done");
    for (int k = 0; k < 2; k++) begin
      wr(8'h60, {k[0], 7'h02});
      frame({8'h11, 8'h7D, 8'h7D, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66},
        1'b0, 1'b0);
      wr(8'h60, {k[0], 12'h002});
      src.fifo_full <= 1'b1;
      mk(8);
      frame(pay, 1'b0, 1'b1);
      src.fifo_full <= 1'b0;
    end
    rchk("frame count", 8'h68, nframes);
    $display("escape and monitor test done");
    wr(8'h64, 32'h4);
    for (int k = 0; k < 2; k++) begin
      wr(8'h60, {k[0], 6'h02});
      skip_data = k[0];
      mk(10);
      frame(pay, 1'b0, 1'b0);
    end
    skip_data = 1'b0;
    rchk("oversize count", 8'h70, 32'h2);
    chk_reg("pending entries", 32'h0, eq.size());
    chk_reg("dropped packets", drops, src.drop_cnt);
    $display("oversize test done");
    finish_test();
  end
endmodule

/* File: hdl/phrc_dscr.sv */
// Purpose: self-synchronous x48 descrambler after destuffing
// Assumes: bits enter lsb first, one byte per valid cycle
// Notes:   history runs even when bypassed, so it resyncs at once
`timescale 1ns/1ps
module phrc_dscr import phrc_pkg::*; (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // byte in
  input  wire logic       in_valid,
  input  wire logic [7:0] in_byte,
  input  wire logic       en,
  // byte out
  output logic [7:0]      out_byte
);
  phrc_dsc_st_t s_q;
  phrc_dsc_st_t s_d;

  always_comb begin
    s_d = s_q;
    for (int i = 0; i < 8; i++) begin
      out_byte[i] = in_byte[i] ^ (en & (s_d.hist[`PHRC_DSC_TAP1-1] ^
                    s_d.hist[`PHRC_DSC_TAP2-1] ^
                    s_d.hist[`PHRC_DSC_LEN-1])); // [R6]
      s_d.hist = {s_d.hist[`PHRC_DSC_LEN-2:0], in_byte[i]};
    end
    if (!in_valid) begin
      s_d = s_q;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_dscr_bypass;
    in_valid && !en |-> out_byte == in_byte;
  endproperty
  a_dscr_bypass: assert property (p_dscr_bypass) // [R6]
    else $error("byte changed with descrambler off");
  property p_dscr_taps;
    in_valid && en |-> out_byte[0] ==
      (in_byte[0] ^ s_q.hist[26] ^ s_q.hist[27] ^ s_q.hist[47]);
  endproperty
  a_dscr_taps: assert property (p_dscr_taps) // [R6]
    else $error("descrambler taps wrong");
endmodule

/* File: hdl/phrc_esc.sv */
// Purpose: escape pair removal and byte destuffing
// Assumes: one raw byte per valid cycle
// Notes:   outputs are combinational from input and state
`timescale 1ns/1ps
module phrc_esc import phrc_pkg::*; (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // raw bytes
  input  wire logic       in_valid,
  input  wire logic [7:0] in_byte,
  input  wire logic       rm_en,
  // destuffed bytes and delimiters
  output logic            out_valid,
  output logic [7:0]      out_byte,
  output logic            out_flag,
  output logic            out_abort
);
  phrc_esc_st_t s_q;
  phrc_esc_st_t s_d;

  always_comb begin
    s_d       = s_q;
    out_valid = 1'b0;
    out_byte  = in_byte;
    out_flag  = 1'b0;
    out_abort = 1'b0;
    if (in_valid) begin
      if (s_q.esc) begin
        s_d.esc = 1'b0;
        if (in_byte == `PHRC_FLAG) begin
          out_abort = 1'b1;
        end else if (in_byte == `PHRC_ESC && rm_en) begin
          out_valid = 1'b0; // [R8]
        end else begin
          out_valid = 1'b1; // [R7]
          out_byte  = in_byte ^ `PHRC_XOR;
        end
      end else if (in_byte == `PHRC_ESC) begin
        s_d.esc = 1'b1;
      end else if (in_byte == `PHRC_FLAG) begin
        out_flag = 1'b1;
      end else begin
        out_valid = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_pair_5d;
    (in_valid && in_byte == `PHRC_ESC && !s_q.esc) ##1
    (in_valid && in_byte == `PHRC_ESC && !rm_en)
    |-> out_valid && out_byte == 8'h5D;
  endproperty
  a_pair_5d: assert property (p_pair_5d) // [R7]
    else $error("escape pair not turned into one byte");
  property p_pair_drop;
    (in_valid && in_byte == `PHRC_ESC && !s_q.esc) ##1
    (in_valid && in_byte == `PHRC_ESC && rm_en)
    |-> !out_valid ##1 !s_q.esc;
  endproperty
  a_pair_drop: assert property (p_pair_drop) // [R8]
    else $error("escape pair reached destuffing");
endmodule

/* File: hdl/phrc_top.sv */
// Purpose: receive hdlc controller with ahb-lite configuration
// Assumes: path bytes and fifo_full share mclk; word accesses only
// Notes:   fifo_full must leave room for the write issued next cycle
//
// The AHB-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
// Functional notes
// R1: frame monitor counts all frames, or only frames written when bit set
// R2: byte counter counts written bytes, or only bytes of good frames
// R3: fcs-failed frames marked errored only when marking bit is set
// R4: fcs bytes stripped unless pass bit set, then written after contents
// R5: address/control pass forces fcs stripping regardless of fcs pass bit
// R6: optional x48+x28+x27+1 self-sync descrambling after destuffing
// R7: without pair removal, escape pair 7D 7D yields single byte 5D
// R8: with pair removal, every escape pair dropped before destuffing
// R9: oversize without discard is not flagged, rest of packet written
// R10: oversize with discard flagged errored, writing stops until next frame
// R11: oversize counter counts every oversize frame, whatever discard says
// R12: fifo reader discards packets marked errored for oversize
// R13: address and control bytes written only when their pass bit is set
// R14: unused upper configuration bits read zero, writes ignored
module phrc_top import phrc_pkg::*; (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // de-mapped path bytes
  input  wire phrc_rx_t    rx,
  // receive fifo write side
  input  wire logic        fifo_full,
  output logic             fifo_wr,
  output phrc_fifo_t       fifo_word
);
  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0]   rsync_q;
  logic         rst_n_s;
  phrc_top_st_t s_q;
  phrc_top_st_t n;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rsync_q <= 2'b00;
    end else begin
      rsync_q <= {rsync_q[0], 1'b1};
    end
  end
  assign rst_n_s = rsync_q[1];

  // ----------------------------------------------------------------
  // configuration fields
  // ----------------------------------------------------------------
  logic wronly, good_only, fcs_mark, fcs_pass, tr_en, rm_en;
  logic ovs_dis, ac_pass, pass_eff;
  assign wronly    = s_q.cfg[`PHRC_B_WRONLY];
  assign good_only = s_q.cfg[`PHRC_B_GOODB];
  assign fcs_mark  = s_q.cfg[`PHRC_B_FCSMARK];
  assign fcs_pass  = s_q.cfg[`PHRC_B_FCSPASS];
  assign tr_en     = s_q.cfg[`PHRC_B_TRDSC];
  assign rm_en     = s_q.cfg[`PHRC_B_PAIRRM];
  assign ovs_dis   = s_q.cfg[`PHRC_B_OVSDIS];
  assign ac_pass   = s_q.cfg[`PHRC_B_ACPASS];
  assign pass_eff  = fcs_pass & ~ac_pass; // [R4] [R5]

  // ----------------------------------------------------------------
  // destuffing and descrambling
  // ----------------------------------------------------------------
  logic       dval;
  logic [7:0] sbyte;
  logic [7:0] dbyte;
  logic       eflag;
  logic       eabort;

  phrc_esc u_esc (
    .mclk      (mclk),
    .rst_n     (rst_n_s),
    .in_valid  (rx.valid),
    .in_byte   (rx.data),
    .rm_en     (rm_en),
    .out_valid (dval),
    .out_byte  (sbyte),
    .out_flag  (eflag),
    .out_abort (eabort)
  );

  phrc_dscr u_dscr (
    .mclk     (mclk),
    .rst_n    (rst_n_s),
    .in_valid (dval),
    .in_byte  (sbyte),
    .en       (tr_en),
    .out_byte (dbyte)
  );

  // ----------------------------------------------------------------
  // frame events
  // ----------------------------------------------------------------
  logic        in_frame, restart, w_avail, w_skip, ovs_hit, ovs_drop;
  logic        data_wr, data_ok, frm_end, end_err, frm_good, frm_inc;
  logic [15:0] pos_inc;
  logic [15:0] w_idx;
  logic [7:0]  w_byte;
  logic [31:0] byte_add;

  assign in_frame = (s_q.st == PHRC_FRAME);
  assign restart  = eflag | eabort;
  assign pos_inc  = (s_q.pos == 16'hFFFF) ? s_q.pos : s_q.pos + 16'h0001;
  // fcs is held back in the delay line until the frame proves longer
  assign w_avail  = pass_eff | (s_q.pos >= `PHRC_FCS_LEN); // [R4]
  assign w_idx    = pass_eff ? s_q.pos : s_q.pos - `PHRC_FCS_LEN;
  assign w_byte   = pass_eff ? dbyte : s_q.dly[31:24];
  assign w_skip   = ~ac_pass & (w_idx < `PHRC_AC_LEN); // [R13]
  assign ovs_hit  = in_frame & dval & ~s_q.ovs &
                    ({1'b0, pos_inc} >
                     ({1'b0, s_q.maxpl} + {1'b0, `PHRC_FCS_LEN}));
  assign ovs_drop = ovs_hit & ovs_dis; // [R10]
  assign data_wr  = in_frame & dval & ~ovs_drop & w_avail & ~w_skip;
  assign data_ok  = data_wr & ~fifo_full;
  assign frm_end  = in_frame & restart & (s_q.pos != 16'h0000);
  assign end_err  = eabort | s_q.ovf | (fcs_mark & rx.fcs_bad); // [R3]
  assign frm_good = ~eabort & ~s_q.ovf & ~rx.fcs_bad;
  assign frm_inc  = frm_end ? (~wronly | ~s_q.ovf)
                            : (ovs_drop & ~wronly); // [R1]
  assign byte_add = good_only ? ((frm_end & frm_good) ? s_q.fb_cnt
                                                       : 32'h0000_0000)
                              : {31'h0000_0000, data_ok}; // [R2]

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic a_ph, clr_frm, clr_byte, clr_ovs;
  assign a_ph     = hsel & htrans[1] & hready;
  // each counter clears on a write to its own offset; a same-cycle event still counts
  assign clr_frm  = s_q.hwr_pend & (s_q.hwaddr == `PHRC_OFF_FRMCNT);
  assign clr_byte = s_q.hwr_pend & (s_q.hwaddr == `PHRC_OFF_BYTECNT);
  assign clr_ovs  = s_q.hwr_pend & (s_q.hwaddr == `PHRC_OFF_OVSCNT);

  function automatic logic [31:0] rd_mux(input logic [7:0]   a,
                                         input phrc_top_st_t s);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (a)
      `PHRC_OFF_CFG:     r = {16'h0000, s.cfg};
      `PHRC_OFF_MAXPL:   r = {16'h0000, s.maxpl};
      `PHRC_OFF_FRMCNT:  r = s.frm_cnt;
      `PHRC_OFF_BYTECNT: r = s.byte_cnt;
      `PHRC_OFF_OVSCNT:  r = s.ovs_cnt;
      default:           r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    n           = s_q;
    n.fifo_wr   = 1'b0;
    n.fifo_word = '0;
    n.hready    = 1'b1;
    n.hresp     = 1'b0;
    if (s_q.hwr_pend) begin
      if (s_q.hwaddr == `PHRC_OFF_CFG) begin
        n.cfg = hwdata[15:0] & `PHRC_CFG_MASK; // [R14]
      end
      if (s_q.hwaddr == `PHRC_OFF_MAXPL) begin
        n.maxpl = hwdata[15:0];
      end
    end
    n.hwr_pend = a_ph & hwrite;
    n.hwaddr   = haddr[7:0];
    if (a_ph && !hwrite) begin
      n.hrdata = rd_mux(haddr[7:0], s_q);
    end
    n.frm_cnt  = (clr_frm ? 32'h0000_0000 : s_q.frm_cnt) +
                 {31'h0000_0000, frm_inc}; // [R1]
    n.byte_cnt = (clr_byte ? 32'h0000_0000 : s_q.byte_cnt) +
                 byte_add; // [R2]
    n.ovs_cnt  = (clr_ovs ? 32'h0000_0000 : s_q.ovs_cnt) +
                 {31'h0000_0000, ovs_hit}; // [R11]
    unique case (s_q.st)
      PHRC_HUNT, PHRC_DISCARD: begin
        if (restart) begin
          n.st = PHRC_FRAME; // [R10]
        end
      end
      PHRC_FRAME: begin
        if (restart) begin
          if (frm_end) begin
            n.fifo_wr            = ~fifo_full;
            n.fifo_word.end_mark = 1'b1;
            n.fifo_word.err      = end_err; // [R3]
          end
        end else if (dval) begin
          n.pos = pos_inc;
          n.dly = {s_q.dly[23:0], dbyte};
          if (ovs_hit) begin
            n.ovs = 1'b1; // [R9]
          end
          if (ovs_drop) begin
            n.fifo_wr            = ~fifo_full;
            n.fifo_word.end_mark = 1'b1;
            n.fifo_word.err      = 1'b1;
            n.st                 = PHRC_DISCARD; // [R10]
          end else if (data_wr) begin
            if (fifo_full) begin
              n.ovf = 1'b1;
            end else begin
              n.fifo_wr        = 1'b1; // [R4] [R13] [R9]
              n.fifo_word.data = w_byte;
              n.fifo_word.sop  = ~s_q.sop_done;
              n.sop_done       = 1'b1;
              n.fb_cnt         = s_q.fb_cnt + 32'h0000_0001;
            end
          end
        end
      end
      default: n.st = PHRC_HUNT;
    endcase
    if (restart) begin
      n.pos      = 16'h0000;
      n.sop_done = 1'b0;
      n.ovf      = 1'b0;
      n.ovs      = 1'b0;
      n.fb_cnt   = 32'h0000_0000;
    end
  end

  always_ff @(posedge mclk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      s_q        <= '0;
      s_q.st     <= PHRC_HUNT;
      s_q.cfg    <= `PHRC_CFG_RST;
      s_q.maxpl  <= `PHRC_MAXPL_RST;
      s_q.hready <= 1'b1;
    end else begin
      s_q <= n;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign hrdata    = s_q.hrdata;
  assign hreadyout = s_q.hready;
  assign hresp     = s_q.hresp;
  assign fifo_wr   = s_q.fifo_wr;
  assign fifo_word = s_q.fifo_word;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n_s);

  property p_strip_lag;
    in_frame && dval && !ovs_drop && !pass_eff &&
    s_q.pos < `PHRC_FCS_LEN |=> !fifo_wr;
  endproperty
  a_strip_lag: assert property (p_strip_lag) // [R4]
    else $error("byte written before fcs hold-back");
  property p_fcs_pass;
    pass_eff && in_frame && dval && !ovs_drop && !w_skip && !fifo_full
    |=> fifo_wr && fifo_word.data == $past(dbyte);
  endproperty
  a_fcs_pass: assert property (p_fcs_pass) // [R4]
    else $error("byte not passed straight through");
  property p_ac_force;
    ac_pass && in_frame && dval && !ovs_drop &&
    s_q.pos < `PHRC_FCS_LEN |=> !fifo_wr;
  endproperty
  a_ac_force: assert property (p_ac_force) // [R5]
    else $error("fcs not held back with ac pass");
  property p_fcs_mark;
    frm_end && eflag && rx.fcs_bad && !fifo_full |=>
    fifo_wr && fifo_word.end_mark &&
    fifo_word.err == ($past(fcs_mark) | $past(s_q.ovf));
  endproperty
  a_fcs_mark: assert property (p_fcs_mark) // [R3]
    else $error("fcs error marking wrong");
  property p_ac_strip;
    in_frame && dval && !ovs_drop && w_avail && !ac_pass &&
    w_idx < `PHRC_AC_LEN |=> !fifo_wr;
  endproperty
  a_ac_strip: assert property (p_ac_strip) // [R13]
    else $error("address or control byte written");
  property p_ovs_count;
    ovs_hit && !clr_ovs |=> s_q.ovs_cnt == $past(s_q.ovs_cnt) + 32'h1;
  endproperty
  a_ovs_count: assert property (p_ovs_count) // [R11]
    else $error("oversize frame not counted");
  property p_ovs_drop;
    ovs_hit && ovs_dis && !fifo_full |=> fifo_wr && fifo_word.end_mark
    && fifo_word.err && s_q.st == PHRC_DISCARD;
  endproperty
  a_ovs_drop: assert property (p_ovs_drop) // [R10]
    else $error("oversize frame not marked and dropped");
  property p_discard_quiet;
    s_q.st == PHRC_DISCARD && !restart |=> !fifo_wr;
  endproperty
  a_discard_quiet: assert property (p_discard_quiet) // [R10]
    else $error("write while discarding");
  property p_ovs_keep;
    ovs_hit && !ovs_dis |=> !(fifo_wr && fifo_word.end_mark) &&
    s_q.st == PHRC_FRAME;
  endproperty
  a_ovs_keep: assert property (p_ovs_keep) // [R9]
    else $error("oversize flagged with discard off");
  property p_frm_wronly;
    frm_end && wronly && s_q.ovf && !clr_frm |=>
    $stable(s_q.frm_cnt);
  endproperty
  a_frm_wronly: assert property (p_frm_wronly) // [R1]
    else $error("overflowed frame counted");
  property p_frm_all;
    frm_end && !wronly && !clr_frm |=>
    s_q.frm_cnt == $past(s_q.frm_cnt) + 32'h1;
  endproperty
  a_frm_all: assert property (p_frm_all) // [R1]
    else $error("frame not counted");
  property p_byte_all;
    data_ok && !good_only && !clr_byte |=>
    s_q.byte_cnt == $past(s_q.byte_cnt) + 32'h1;
  endproperty
  a_byte_all: assert property (p_byte_all) // [R2]
    else $error("written byte not counted");
  property p_cfg_rd;
    a_ph && !hwrite && haddr[7:0] == `PHRC_OFF_CFG |=>
    hrdata[31:13] == 19'h00000;
  endproperty
  a_cfg_rd: assert property (p_cfg_rd) // [R14]
    else $error("unused config bits not zero");

  c_frame_end: cover property (frm_end && eflag && !s_q.ovf);
  c_abort:     cover property (frm_end && eabort);
  c_ovs_drop:  cover property (ovs_drop);
  c_overflow:  cover property (data_wr && fifo_full);
endmodule

/* File: pkg/phrc_cfg.svh */
// Purpose: offsets, field positions, reset values and byte codes
// Assumes: byte addresses on a 32-bit AHB-Lite bus
// Notes:   included by the package file; the design files use its macros
`ifndef PHRC_CFG_SVH
`define PHRC_CFG_SVH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define PHRC_OFF_CFG      8'h60
`define PHRC_OFF_MAXPL    8'h64
`define PHRC_OFF_FRMCNT   8'h68
`define PHRC_OFF_BYTECNT  8'h6C
`define PHRC_OFF_OVSCNT   8'h70
// ----------------------------------------------------------------
// reset values and configuration fields
// ----------------------------------------------------------------
`define PHRC_CFG_RST      16'h006F
`define PHRC_CFG_MASK     16'h1FFF
`define PHRC_MAXPL_RST    16'h05DC
`define PHRC_B_WRONLY     12
`define PHRC_B_GOODB      11
`define PHRC_B_FCSMARK    10
`define PHRC_B_FCSPASS    9
`define PHRC_B_TRDSC      8
`define PHRC_B_PAIRRM     7
`define PHRC_B_OVSDIS     6
`define PHRC_B_ACPASS     1
// ----------------------------------------------------------------
// framing
// ----------------------------------------------------------------
`define PHRC_FLAG         8'h7E
`define PHRC_ESC          8'h7D
`define PHRC_XOR          8'h20
`define PHRC_FCS_LEN      16'h0004
`define PHRC_AC_LEN       16'h0002
`define PHRC_DSC_LEN      48
`define PHRC_DSC_TAP1     27
`define PHRC_DSC_TAP2     28
`endif

/* File: pkg/phrc_pkg.sv */
// Purpose: shared types of the receive hdlc block
// Assumes: phrc_cfg.svh on the include path
// Notes:   module state other than the top reset synchronizer is held in the structs below
`include "phrc_cfg.svh"
package phrc_pkg;
  // --------------------------------------------------------------
  // frame states
  // --------------------------------------------------------------
  typedef enum logic [1:0] {
    PHRC_HUNT    = 2'b00,
    PHRC_FRAME   = 2'b01,
    PHRC_DISCARD = 2'b10
  } phrc_fsm_t;
  // --------------------------------------------------------------
  // carriers
  // --------------------------------------------------------------
  typedef struct packed {
    logic       valid;
    logic       fcs_bad;
    logic [7:0] data;
  } phrc_rx_t;
  typedef struct packed {
    logic       sop;
    logic       end_mark;
    logic       err;
    logic [7:0] data;
  } phrc_fifo_t;
  // --------------------------------------------------------------
  // module state
  // --------------------------------------------------------------
  typedef struct packed {
    logic esc;
  } phrc_esc_st_t;
  typedef struct packed {
    logic [`PHRC_DSC_LEN-1:0] hist;
  } phrc_dsc_st_t;
  typedef struct packed {
    phrc_fsm_t  st;
    logic [15:0] cfg;
    logic [15:0] maxpl;
    logic [31:0] frm_cnt;
    logic [31:0] byte_cnt;
    logic [31:0] ovs_cnt;
    logic [31:0] fb_cnt;
    logic [15:0] pos;
    logic [31:0] dly;
    logic        sop_done;
    logic        ovf;
    logic        ovs;
    logic        fifo_wr;
    phrc_fifo_t  fifo_word;
    logic        hwr_pend;
    logic [7:0]  hwaddr;
    logic [31:0] hrdata;
    logic        hready;
    logic        hresp;
  } phrc_top_st_t;
endpackage
